// ==== src/boot_sleep_consts.svh ====
// Constants for the boot-default and sleep control block.
// Assumes one 200 MHz clock and a synchronous active-high reset.
// Summary of operation
// RL1: RTC regulator off-state power select, default 0
// RL2: Slow clock source select, default crystal
// RL3: Keep-on request holds device powered, default 0
// RL4: Slot length 0.5 ms or 2 ms, default 2
// RL5: Long press turns device off, default 1
// RL6: Core reset once off after press, default 1
// RL7: Interrupt output polarity select, default low
// RL8: Supply-insert mask gates auto switch-on, default 1
// RL9: Pin 4/5 edge masks, falls 1 rises 0
// RL10: Pin 0 open-drain select bit stored, default 0; pin 0 driven push-pull except during reset
// RL11: Watchdog enable, 100 s period, default 1
// RL12: Divider buffer bypass, default buffer disabled
// RL13: Boot gate threshold field, default 3.1 V
// RL14: Auto keep-on sets keep-on after power-on
// RL15: Power-down input polarity, default active-low
// RL16: Sleep edge enters SLEEP unless disabled
// RL17: Opposite sleep edge returns to ACTIVE
// RL18: Sleep input polarity selectable, no debouncing
// RL19: Keep masks hold resources active in SLEEP
// RL20: Switcher mask bit keeps slow clock running
// RL21: External enable outputs follow sleep state
// RL22: Boot select pin picks fixed or stored values
// RL23: Sleep input synchronised before edge detection
`ifndef BOOT_SLEEP_CONSTS_SVH
`define BOOT_SLEEP_CONSTS_SVH

// Fixed-boot defaults
`define FIX_RTC_OFF_POWER      1'h0
`define FIX_CLOCK_SOURCE       1'h0
`define FIX_KEEP_ON            1'h0
`define FIX_SLOT_LENGTH        1'h1
`define FIX_LP_OFF             1'h1
`define FIX_LP_RESET           1'h1
`define FIX_IRQ_POL            1'h0
`define FIX_SUPPLY_MASK        1'h1
`define FIX_FALL_MASK          1'h1
`define FIX_RISE_MASK          1'h0
`define FIX_OPEN_DRAIN         1'h0
`define FIX_WDOG_EN            1'h1
`define FIX_BUF_BYPASS         1'h1
`define FIX_THRESHOLD          5'h0c
`define FIX_AUTO_KEEP_ON       1'h1
`define FIX_PD_POL             1'h0

// Register map
`define ADDR_CTRL              4'h0
`define ADDR_SLEEP_CFG         4'h1
`define ADDR_LINEAR_MASK       4'h2
`define ADDR_SWITCHER_MASK     4'h3
`define ADDR_STATUS            4'h4
`define ADDR_EXT_ENABLE        4'h5
// Switcher mask bit for the slow clock output
`define SW_CLK_BIT             7
// Count reached in BOOT before ACTIVE (BOOT lasts 3 cycles) so the boot select pin clears its synchroniser
`define BOOT_SYNC_CYC          2'h2

// Timing
`define CLK_HZ                 200000000
`define SLOT_SHORT_US          500
`define SLOT_LONG_US           2000
`define SLOT_SHORT_CYC   ((`SLOT_SHORT_US * (`CLK_HZ / 1000000)))
`define SLOT_LONG_CYC    ((`SLOT_LONG_US * (`CLK_HZ / 1000000)))
`define WDOG_PERIOD_S          100
`define WDOG_CYC         (64'd100 * 64'd200000000)
`endif

// ==== src/boot_sleep_pkg.sv ====
// Types for the boot-default and sleep control block.
// Assumes boot_sleep_consts.svh supplies the numbers.
package boot_sleep_pkg;

	// General control bits loaded at boot
	typedef struct packed {
		logic       rtc_ldo_off_power_sel;
		logic       slow_clock_source_sel;
		logic       keep_on_request;
		logic       slot_length_sel;
		logic       button_long_press_off_en;
		logic       button_long_press_core_reset;
		logic       irq_polarity_sel;
		logic       supply_insert_irq_mask;
		logic       pin5_fall_irq_mask;
		logic       pin5_rise_irq_mask;
		logic       pin4_fall_irq_mask;
		logic       pin4_rise_irq_mask;
		logic       pin0_open_drain_sel;
		logic       watchdog_en;
		logic       divider_buffer_bypass;
		logic [4:0] boot_gate_threshold;
		logic       auto_keep_on_sel;
		logic       power_down_input_polarity;
	} boot_ctrl_t;

	// Power state, Gray coded
	typedef enum logic [1:0] {
		ST_BOOT   = 2'h0,
		ST_ACTIVE = 2'h1,
		ST_SLEEP  = 2'h3
	} power_state_t;

endpackage

// ==== src/sync_two_ff.sv ====
// Two-flip-flop level synchroniser.
// Assumes the input is asynchronous to clk.
`timescale 1ns/100ps
module sync_two_ff #(
	parameter int WIDTH = 1
) (
	// Clock and reset
	input  wire logic             clk,
	input  wire logic             reset,
	// Data
	input  wire logic [WIDTH-1:0] async_in,
	output logic      [WIDTH-1:0] sync_out
);
	logic [WIDTH-1:0] meta_reg;

	// First stage read only by second stage
	always_ff @(posedge clk) begin
		if (reset) begin
			meta_reg <= '0;
			sync_out <= '0;
		end else begin
			meta_reg <= async_in;
			sync_out <= meta_reg;
		end
	end
endmodule

// ==== src/period_tick.sv ====
// Programmable period divider giving a one-cycle enable pulse.
// Assumes period is held steady while enabled.
`timescale 1ns/100ps
module period_tick #(
	parameter int CW = 40
) (
	// Clock and reset
	input  wire logic          clk,
	input  wire logic          reset,
	// Control
	input  wire logic          enable,
	input  wire logic [CW-1:0] period,
	// Pulse
	output logic               tick
);
	logic [CW-1:0] count_reg;

	// Count up and pulse on wrap
	always_ff @(posedge clk) begin
		if (reset || !enable) begin
			count_reg <= '0;
			tick      <= 1'b0;
		end else if (count_reg >= period - CW'(1)) begin
			count_reg <= '0;
			tick      <= 1'b1;
		end else begin
			count_reg <= count_reg + CW'(1);
			tick      <= 1'b0;
		end
	end
endmodule

// ==== src/boot_defaults_sleep_control.sv ====
// Boot-default control bits and sleep state control.
// Assumes a host on the register port and async pins from outside.
//
// The plain strobed port and the placing of the registers were left to the implementer.
`timescale 1ns/100ps
`include "boot_sleep_consts.svh"
module boot_defaults_sleep_control #(
	parameter int        NLIN       = 8,
	parameter int        NSW        = 8,
	parameter logic [63:0] WDOG_CYCLES = `WDOG_CYC
) (
	// Clock and reset
	input  wire logic                        clk,
	input  wire logic                        reset,
	// Register port
	input  wire logic [3:0]                  addr,
	input  wire logic [31:0]                 wdata,
	input  wire logic                        wr_en,
	input  wire logic                        rd_en,
	output logic      [31:0]                 rdata,
	// Pins
	input  wire logic                        boot_select_pin,
	input  wire logic                        sleep_pin,
	input  wire logic                        sleep_disable,
	input  wire logic                        irq_event,
	input  wire logic                        button_long_press,
	input  wire logic                        device_off,
	input  wire logic                        power_on_done,
	// Stored boot values
	input  wire boot_sleep_pkg::boot_ctrl_t  stored_ctrl,
	// Outputs
	output boot_sleep_pkg::boot_ctrl_t       ctrl_out,
	output logic                             in_sleep,
	output logic                             slot_tick,
	output logic                             watchdog_tick,
	output logic                             irq_out,
	output logic                             slow_clock_output_en,
	output logic      [NLIN-1:0]             linear_full_power,
	output logic      [NSW-1:0]              switcher_full_power,
	output logic      [3:0]                  ext_enable_out,
	output logic                             power_off_req,
	output logic                             core_reset_req,
	output logic                             pin0_drive_oe_n
);
	boot_sleep_pkg::boot_ctrl_t   ctrl_reg;
	boot_sleep_pkg::power_state_t state_reg;
	logic [NLIN-1:0] lin_mask_reg;
	logic [NSW-1:0]  sw_mask_reg;
	logic [3:0]      ext_sleep_reg;
	logic [3:0]      ext_act_reg;
	logic            sleep_inv_reg;
	logic            sleep_s;
	logic            sleep_prev_reg;
	logic            boot_s;
	logic            sleep_lvl;
	logic            sleep_enter;
	logic            sleep_exit;
	logic            slot_pulse;
	logic            wdog_pulse;
	logic [39:0]     slot_period;
	logic [1:0]      boot_wait_reg;

	// Hold BOOT until the synchronised boot select is valid
	always_ff @(posedge clk) begin
		if (reset)
			boot_wait_reg <= 2'h0;
		else if (state_reg == boot_sleep_pkg::ST_BOOT &&
				boot_wait_reg != `BOOT_SYNC_CYC)
			boot_wait_reg <= boot_wait_reg + 2'h1; // RL22
	end

	// Sleep and boot select pins cross into the clock domain
	sync_two_ff #(.WIDTH(2)) u_sync (
		.clk      (clk),
		.reset    (reset),
		.async_in ({sleep_pin, boot_select_pin}),
		.sync_out ({sleep_s, boot_s})
	); // RL23

	// Polarity-corrected sleep level, low means asleep
	assign sleep_lvl   = sleep_s ^ sleep_inv_reg; // RL18
	assign sleep_enter = sleep_prev_reg && !sleep_lvl; // RL16
	assign sleep_exit  = !sleep_prev_reg && sleep_lvl; // RL17

	// Edge history of the synchronised level
	always_ff @(posedge clk) begin
		if (reset)
			sleep_prev_reg <= 1'b1;
		else
			sleep_prev_reg <= sleep_lvl;
	end

	// Boot load picks fixed or stored bits, then host writes
	always_ff @(posedge clk) begin
		if (reset) begin
			ctrl_reg <= '0;
		end else if (state_reg == boot_sleep_pkg::ST_BOOT) begin
			if (boot_s) begin // RL22
				ctrl_reg <= stored_ctrl;
			end else begin
				ctrl_reg.rtc_ldo_off_power_sel <= `FIX_RTC_OFF_POWER; // RL1
				ctrl_reg.slow_clock_source_sel <= `FIX_CLOCK_SOURCE; // RL2
				ctrl_reg.keep_on_request <= `FIX_KEEP_ON; // RL3
				ctrl_reg.slot_length_sel <= `FIX_SLOT_LENGTH; // RL4
				ctrl_reg.button_long_press_off_en <= `FIX_LP_OFF; // RL5
				ctrl_reg.button_long_press_core_reset <= `FIX_LP_RESET; // RL6
				ctrl_reg.irq_polarity_sel <= `FIX_IRQ_POL; // RL7
				ctrl_reg.supply_insert_irq_mask <= `FIX_SUPPLY_MASK; // RL8
				ctrl_reg.pin5_fall_irq_mask <= `FIX_FALL_MASK; // RL9
				ctrl_reg.pin5_rise_irq_mask <= `FIX_RISE_MASK; // RL9
				ctrl_reg.pin4_fall_irq_mask <= `FIX_FALL_MASK; // RL9
				ctrl_reg.pin4_rise_irq_mask <= `FIX_RISE_MASK; // RL9
				ctrl_reg.pin0_open_drain_sel <= `FIX_OPEN_DRAIN; // RL10
				ctrl_reg.watchdog_en <= `FIX_WDOG_EN; // RL11
				ctrl_reg.divider_buffer_bypass <= `FIX_BUF_BYPASS; // RL12
				ctrl_reg.boot_gate_threshold <= `FIX_THRESHOLD; // RL13
				ctrl_reg.auto_keep_on_sel <= `FIX_AUTO_KEEP_ON; // RL14
				ctrl_reg.power_down_input_polarity <= `FIX_PD_POL; // RL15
			end
		end else if (wr_en && addr == `ADDR_CTRL) begin
			ctrl_reg <= boot_sleep_pkg::boot_ctrl_t'(wdata[21:0]);
		end else if (power_on_done && ctrl_reg.auto_keep_on_sel) begin
			ctrl_reg.keep_on_request <= 1'b1; // RL14
		end
	end

	// Sleep configuration and keep masks written by the host
	always_ff @(posedge clk) begin
		if (reset) begin
			sleep_inv_reg <= 1'b0;
			lin_mask_reg  <= '0;
			sw_mask_reg   <= '0;
			ext_sleep_reg <= '0;
			ext_act_reg   <= '1;
		end else if (wr_en) begin
			case (addr)
			`ADDR_SLEEP_CFG: sleep_inv_reg <= wdata[0];
			`ADDR_LINEAR_MASK: lin_mask_reg <= wdata[NLIN-1:0];
			`ADDR_SWITCHER_MASK: sw_mask_reg <= wdata[NSW-1:0];
			`ADDR_EXT_ENABLE: begin
				ext_act_reg   <= wdata[3:0];
				ext_sleep_reg <= wdata[7:4];
			end
			default: ;
			endcase
		end
	end

	// Power state machine
	always_ff @(posedge clk) begin
		if (reset) begin
			state_reg <= boot_sleep_pkg::ST_BOOT;
		end else begin
			case (state_reg)
			boot_sleep_pkg::ST_BOOT:
				if (boot_wait_reg == `BOOT_SYNC_CYC)
					state_reg <= boot_sleep_pkg::ST_ACTIVE; // RL22
			boot_sleep_pkg::ST_ACTIVE:
				if (sleep_enter && !sleep_disable)
					state_reg <= boot_sleep_pkg::ST_SLEEP; // RL16
			boot_sleep_pkg::ST_SLEEP:
				if (sleep_exit)
					state_reg <= boot_sleep_pkg::ST_ACTIVE; // RL17
			default:
				state_reg <= boot_sleep_pkg::ST_BOOT;
			endcase
		end
	end

	// Slot and watchdog dividers
	assign slot_period = ctrl_reg.slot_length_sel ?
		40'(`SLOT_LONG_CYC) : 40'(`SLOT_SHORT_CYC); // RL4
	period_tick #(.CW(40)) u_slot (
		.clk    (clk),
		.reset  (reset),
		.enable (1'b1),
		.period (slot_period),
		.tick   (slot_pulse)
	);
	period_tick #(.CW(40)) u_wdog (
		.clk    (clk),
		.reset  (reset),
		.enable (ctrl_reg.watchdog_en), // RL11
		.period (WDOG_CYCLES[39:0]),
		.tick   (wdog_pulse)
	);

	// Registered outputs
	always_ff @(posedge clk) begin
		if (reset) begin
			ctrl_out             <= '0;
			in_sleep             <= 1'b0;
			slot_tick            <= 1'b0;
			watchdog_tick        <= 1'b0;
			irq_out              <= 1'b1;
			slow_clock_output_en <= 1'b0;
			linear_full_power    <= '0;
			switcher_full_power  <= '0;
			ext_enable_out       <= '0;
			power_off_req        <= 1'b0;
			core_reset_req       <= 1'b0;
			pin0_drive_oe_n      <= 1'b1;
		end else begin
			ctrl_out      <= ctrl_reg;
			in_sleep      <= state_reg == boot_sleep_pkg::ST_SLEEP;
			slot_tick     <= slot_pulse;
			watchdog_tick <= wdog_pulse;
			irq_out       <= irq_event ^ ~ctrl_reg.irq_polarity_sel; // RL7
			if (state_reg == boot_sleep_pkg::ST_SLEEP) begin
				linear_full_power   <= lin_mask_reg; // RL19
				switcher_full_power <= sw_mask_reg; // RL19
				slow_clock_output_en <= sw_mask_reg[`SW_CLK_BIT]; // RL20
				ext_enable_out <= ext_sleep_reg; // RL21
			end else begin
				linear_full_power    <= '1;
				switcher_full_power  <= '1;
				slow_clock_output_en <= state_reg != boot_sleep_pkg::ST_BOOT;
				ext_enable_out <= ext_act_reg; // RL21
			end
			power_off_req  <= button_long_press &&
				ctrl_reg.button_long_press_off_en; // RL5
			core_reset_req <= device_off &&
				ctrl_reg.button_long_press_core_reset; // RL6
			pin0_drive_oe_n <= 1'b0; // RL10
		end
	end

	// Read port, data one cycle after the strobe
	always_ff @(posedge clk) begin
		if (reset) begin
			rdata <= '0;
		end else if (rd_en) begin
			case (addr)
			`ADDR_CTRL: rdata <= {10'h000, ctrl_reg};
			`ADDR_SLEEP_CFG: rdata <= {31'h0, sleep_inv_reg};
			`ADDR_LINEAR_MASK: rdata <= 32'(lin_mask_reg);
			`ADDR_SWITCHER_MASK: rdata <= 32'(sw_mask_reg);
			`ADDR_STATUS: rdata <= {29'h0, sleep_s, state_reg};
			`ADDR_EXT_ENABLE: rdata <= {24'h0, ext_sleep_reg, ext_act_reg};
			default: rdata <= '0;
			endcase
		end else begin
			rdata <= '0;
		end
	end

	// Entry needs a clean edge two cycles after the pin edge
	sequence seq_enter;
		sleep_enter && !sleep_disable &&
			state_reg == boot_sleep_pkg::ST_ACTIVE;
	endsequence

	AST_ENTER: assert property (@(posedge clk) disable iff (reset) // RL16
		seq_enter |=> state_reg == boot_sleep_pkg::ST_SLEEP ##1 in_sleep)
		else $error("sleep entry missed");
	AST_EXIT: assert property (@(posedge clk) disable iff (reset) // RL17
		sleep_exit && state_reg == boot_sleep_pkg::ST_SLEEP
		|=> state_reg == boot_sleep_pkg::ST_ACTIVE)
		else $error("sleep exit missed");
	AST_NOENTER: assert property (@(posedge clk) disable iff (reset) // RL16
		state_reg == boot_sleep_pkg::ST_ACTIVE && sleep_disable
		|=> state_reg != boot_sleep_pkg::ST_SLEEP)
		else $error("sleep entered while disabled");
	AST_KEEP: assert property (@(posedge clk) disable iff (reset) // RL19
		state_reg == boot_sleep_pkg::ST_SLEEP
		|=> linear_full_power == $past(lin_mask_reg))
		else $error("keep mask not applied");
	AST_CLK: assert property (@(posedge clk) disable iff (reset) // RL20
		state_reg == boot_sleep_pkg::ST_SLEEP && !sw_mask_reg[`SW_CLK_BIT]
		|=> !slow_clock_output_en)
		else $error("clock kept without mask");
	AST_FIXED: assert property (@(posedge clk) disable iff (reset) // RL22
		state_reg == boot_sleep_pkg::ST_BOOT && !boot_s
		|=> ctrl_reg.slot_length_sel && ctrl_reg.watchdog_en &&
			ctrl_reg.boot_gate_threshold == `FIX_THRESHOLD)
		else $error("fixed boot values wrong");
	AST_IRQ: assert property (@(posedge clk) disable iff (reset) // RL7
		!ctrl_reg.irq_polarity_sel && irq_event |=> !irq_out)
		else $error("irq polarity wrong");
	AST_LPOFF: assert property (@(posedge clk) disable iff (reset) // RL5
		!ctrl_reg.button_long_press_off_en |=> !power_off_req)
		else $error("off without enable");
endmodule

// ==== verif/host_sleep_model.sv ====
// Host model: drives the sleep input and watches the interrupt line.
// Assumes the bench commands the sleep level and interrupt polarity.
`timescale 1ns/100ps
module host_sleep_model #(
	parameter int LAG = 0
) (
	// Clock
	input  wire logic clk,
	// Commands from the bench
	input  wire logic sleep_cmd,
	input  wire logic irq_active_high,
	// Lines to and from the block
	input  wire logic irq_out,
	output logic      sleep_pin,
	output logic      irq_seen
);
	logic [7:0] lag_reg = 8'hff;

	// Sleep level moves just after an edge; LAG makes a slow host
	always_ff @(posedge clk) begin
		lag_reg <= {lag_reg[6:0], sleep_cmd};
	end
	assign sleep_pin = lag_reg[LAG];

	// Interrupt counts as seen only at its programmed active level
	assign irq_seen = (irq_out === irq_active_high);
endmodule

// ==== verif/tb.sv ====
// Self-checking bench for the boot-default and sleep control block.
// Assumes a 200 MHz clock and the host model on the sleep line.
`timescale 1ns/100ps
`include "boot_sleep_consts.svh"
module tb;
	logic                       clk, reset, wr_en, rd_en;
	logic [3:0]                 addr, ext_enable_out;
	logic [31:0]                wdata, rdata, rd_val;
	logic                       boot_select_pin, sleep_disable, irq_event;
	logic                       button_long_press, device_off, power_on_done;
	logic                       sleep_cmd, irq_active_high, sleep_pin;
	logic                       irq_seen, in_sleep, slot_tick, irq_out;
	logic                       watchdog_tick, slow_clock_output_en;
	logic                       power_off_req, core_reset_req;
	logic                       pin0_drive_oe_n;
	logic [7:0]                 linear_full_power, switcher_full_power;
	boot_sleep_pkg::boot_ctrl_t stored_ctrl, ctrl_out, fix_ctrl;
	int                         err_count, check_count;

	// Device under test with a short watchdog period
	boot_defaults_sleep_control #(.WDOG_CYCLES(64'd100)) dut (
		.clk(clk), .reset(reset), .addr(addr), .wdata(wdata),
		.wr_en(wr_en), .rd_en(rd_en), .rdata(rdata),
		.boot_select_pin(boot_select_pin), .sleep_pin(sleep_pin),
		.sleep_disable(sleep_disable), .irq_event(irq_event),
		.button_long_press(button_long_press), .device_off(device_off),
		.power_on_done(power_on_done), .stored_ctrl(stored_ctrl),
		.ctrl_out(ctrl_out), .in_sleep(in_sleep), .slot_tick(slot_tick),
		.watchdog_tick(watchdog_tick), .irq_out(irq_out),
		.slow_clock_output_en(slow_clock_output_en),
		.linear_full_power(linear_full_power),
		.switcher_full_power(switcher_full_power),
		.ext_enable_out(ext_enable_out), .power_off_req(power_off_req),
		.core_reset_req(core_reset_req), .pin0_drive_oe_n(pin0_drive_oe_n)
	);

	// Host on the far side of the sleep and interrupt lines
	host_sleep_model host (
		.clk(clk), .sleep_cmd(sleep_cmd),
		.irq_active_high(irq_active_high), .irq_out(irq_out),
		.sleep_pin(sleep_pin), .irq_seen(irq_seen)
	);

	// Clock generation
	initial begin
		clk = 1'h0;
		forever #2.5 clk = ~clk;
	end

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp) begin
			err_count++;
			$display("Error t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic cycles(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask

	task automatic wr(input logic [3:0] a, input logic [31:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr_en <= 1'h1;
		@(posedge clk);
		wr_en <= 1'h0;
	endtask

	// Read data stand only in the cycle after the strobe
	task automatic rd(input logic [3:0] a, output logic [31:0] d);
		@(posedge clk);
		addr <= a;
		rd_en <= 1'h1;
		@(posedge clk);
		rd_en <= 1'h0;
		#1;
		d = rdata;
	endtask

	// Bounded wait for the sleep flag to reach a level
	task automatic wait_sleep(input logic v);
		for (int i = 0; i < 10; i++) begin
			cycles(1);
			if (in_sleep === v)
				break;
		end
		chk({31'h0, in_sleep}, {31'h0, v});
	endtask

	task automatic do_reset(input logic sel);
		@(posedge clk);
		boot_select_pin <= sel;
		reset <= 1'h1;
		repeat (5) @(posedge clk);
		reset <= 1'h0;
		cycles(5);
	endtask

	// Long press and off requests against the loaded enables
	task automatic t_press(input logic exp);
		@(posedge clk);
		button_long_press <= 1'h1;
		device_off <= 1'h1;
		cycles(4);
		chk({power_off_req, core_reset_req}, {exp, exp});
		button_long_press <= 1'h0;
		device_off <= 1'h0;
		cycles(2);
	endtask

	// Spacing of watchdog ticks, or none when disabled
	task automatic t_watchdog(input logic en);
		int n;
		n = 0;
		while (watchdog_tick !== 1'h1 && n < 250) begin
			cycles(1);
			n++;
		end
		chk({31'h0, watchdog_tick}, {31'h0, en});
		if (en) begin
			n = 0;
			do begin
				cycles(1);
				n++;
			end while (watchdog_tick !== 1'h1 && n < 250);
			chk(n, 100);
		end
	endtask

	// Sleep entry, exit, masks, disable, polarity and short pulse
	task automatic t_sleep();
		wr(`ADDR_LINEAR_MASK, 32'h5a);
		wr(`ADDR_SWITCHER_MASK, 32'h80);
		wr(`ADDR_EXT_ENABLE, 32'h3c);
		sleep_cmd <= 1'h0;
		wait_sleep(1'h1);
		chk({linear_full_power, switcher_full_power}, 16'h5a80);
		chk({slow_clock_output_en, ext_enable_out}, 5'h13);
		sleep_cmd <= 1'h1;
		wait_sleep(1'h0);
		chk({linear_full_power, ext_enable_out}, 12'hffc);
		rd(`ADDR_STATUS, rd_val);
		chk(rd_val, 32'h5);
		rd(4'hf, rd_val);
		chk(rd_val, 32'h0);
		sleep_disable <= 1'h1;
		sleep_cmd <= 1'h0;
		cycles(8);
		chk({31'h0, in_sleep}, 32'h0);
		sleep_disable <= 1'h0;
		sleep_cmd <= 1'h1;
		cycles(6);
		wr(4'h1, 32'h1);
		wr(`ADDR_SWITCHER_MASK, 32'h0);
		sleep_cmd <= 1'h0;
		cycles(8);
		chk({31'h0, in_sleep}, 32'h0);
		sleep_cmd <= 1'h1;
		wait_sleep(1'h1);
		chk({31'h0, slow_clock_output_en}, 32'h0);
		sleep_cmd <= 1'h0;
		wait_sleep(1'h0);
		wr(4'h1, 32'h0);
		sleep_cmd <= 1'h1;
		cycles(6);
		sleep_cmd <= 1'h0;
		@(posedge clk);
		sleep_cmd <= 1'h1;
		wait_sleep(1'h1);
		wait_sleep(1'h0);
	endtask

	task automatic tally_and_finish();
		$display("checks %0d errors %0d", check_count, err_count);
		if (err_count == 0 && check_count > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	// Watchdog against a hung run
	initial begin
		#(20000 * 5);
		err_count++;
		tally_and_finish();
	end

	// Main sequence
	initial begin
		{reset, wr_en, rd_en, addr, wdata} = '0;
		reset = 1'h1;
		{boot_select_pin, sleep_disable, irq_event} = '0;
		{button_long_press, device_off, power_on_done} = '0;
		{irq_active_high, sleep_cmd} = 2'h1;
		err_count = 0;
		check_count = 0;
		fix_ctrl = {1'h0, 1'h0, 1'h0, 1'h1, 1'h1, 1'h1, 1'h0, 1'h1, 1'h1,
			1'h0, 1'h1, 1'h0, 1'h0, 1'h1, 1'h1, 5'h0c, 1'h1, 1'h0};
		stored_ctrl = ~fix_ctrl;
		do_reset(1'h0);
		chk(ctrl_out, fix_ctrl);
		chk({31'h0, pin0_drive_oe_n}, 32'h0);
		irq_event <= 1'h1;
		irq_active_high <= 1'h0;
		cycles(4);
		chk({31'h0, irq_seen}, 32'h1);
		t_press(1'h1);
		t_watchdog(1'h1);
		power_on_done <= 1'h1;
		cycles(4);
		chk({31'h0, ctrl_out.keep_on_request}, 32'h1);
		t_sleep();
		power_on_done <= 1'h0;
		irq_event <= 1'h0;
		do_reset(1'h1);
		chk(ctrl_out, stored_ctrl);
		rd(`ADDR_CTRL, rd_val);
		chk(rd_val, 32'(stored_ctrl));
		irq_event <= 1'h1;
		irq_active_high <= 1'h1;
		cycles(4);
		chk({31'h0, irq_seen}, 32'h1);
		t_press(1'h0);
		t_watchdog(1'h0);
		tally_and_finish();
	end
endmodule
